// *** core/ure_read_ctrl.sv ***
// read-side setting registers and endpoint/bus controls of the bridge
//
// Contract
// [R1] eop enable at bit 4, resets to 1
// [R2] eop off: one-byte last word not forwarded
// [R3] eop off, two bytes: forward with eop low
// [R4] eop on: last word forwarded with eop high
// [R5] null request accepted only when endpoint empty
// [R6] null request drives flag, self-clears after packet
// [R7] software waits for null request clear
// [R8] burst select bit 8: INCR8 or INCR
// [R9] select affects burst beats, not singles
// [R10] software sets burst select before transfers
// [R11] abort stops reads, clears run enable
// [R12] path reset pulses, then self-clears
// [R13] unused bits ignore writes
`timescale 1ns/1ps
module ure_read_ctrl (
  input wire logic ref_clk,           // 40 MHz bus clock
  input wire logic reset_n,           // async reset, active low
  input wire logic wb_cyc_i,          // wishbone cycle
  input wire logic wb_stb_i,          // wishbone strobe
  input wire logic wb_we_i,           // wishbone write
  input wire logic [3:0] wb_adr_i,    // wishbone byte address
  input wire logic [3:0] wb_sel_i,    // wishbone byte lanes
  input wire logic [31:0] wb_dat_i,   // wishbone write data
  output logic [31:0] wb_dat_o,       // wishbone read data
  output logic wb_ack_o,              // wishbone acknowledge
  input wire logic epEmpty,           // read-side endpoint empty
  input wire logic nullDone,          // null packet sent, pulse
  input wire logic readDone,          // read transfer finished, pulse
  input wire logic wordStrobe,        // read word ready, pulse
  input wire logic wordIsLast,        // word is the last one
  input wire logic lastTwoBytes,      // last word has two bytes
  input wire logic beatIsBurst,       // next bus access is a burst
  output logic endpointNullDataFlag,  // null data toward usb core
  output logic epWrite,               // endpoint write pulse
  output logic epWriteEop,            // endpoint end-of-packet
  output logic readRunEnable,         // read transfers allowed
  output logic readAbortPulse,        // one-cycle abort to read path
  output logic readPathResetPulse,    // one-cycle read path reset
  output logic [2:0] hburst           // burst code for next access
);

  // ***********************************************
  // bus slave
  // ***********************************************
  logic ackR_r;              // ack flop
  logic [31:0] rdData_r;     // read data flop
  logic wrTake;              // write commits on the ack edge
  logic selLink;             // link register addressed
  logic selMst;              // master register addressed
  logic [31:0] rdMux;        // read data before the flop

  logic eopEnable_r;         // end-of-packet enable
  logic burstSel_r;          // burst type select
  logic runEnable_r;         // read run enable
  logic abort_r;             // abort pulse
  logic pathRst_r;           // path reset pulse, readable for a cycle
  logic [2:0] hburst_r;      // burst code flop
  ure_pkg::ure_null_state_t nullState_r; // null sequencer
  ure_pkg::ure_null_state_t nullState_nxt;

  assign selLink = (wb_adr_i == ure_pkg::ADDR_LINK_SET);
  assign selMst = (wb_adr_i == ure_pkg::ADDR_MST_SET);
  assign wrTake = wb_cyc_i & wb_stb_i & wb_we_i & ackR_r;

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      ackR_r <= 1'b0;
    else
      ackR_r <= wb_cyc_i & wb_stb_i & ~ackR_r;
  end

  // read mux; unmapped and unused positions read zero
  always_comb
  begin
    rdMux = 32'h0000_0000;
    if (selLink)
    begin
      rdMux[ure_pkg::BIT_NULL_REQ] = (nullState_r == ure_pkg::NULL_BUSY);
      rdMux[ure_pkg::BIT_EOP_EN] = eopEnable_r;
    end
    else if (selMst)
    begin
      rdMux[ure_pkg::BIT_RUN_EN] = runEnable_r;
      rdMux[ure_pkg::BIT_PATH_RST] = pathRst_r;
      rdMux[ure_pkg::BIT_BURST_SEL] = burstSel_r;
    end
  end

  // sample read data together with the ack
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      rdData_r <= 32'h0000_0000;
    else if (wb_cyc_i & wb_stb_i & ~ackR_r)
      rdData_r <= rdMux;
  end

  // ***********************************************
  // setting bits
  // ***********************************************
  // only defined bits are stored; everything else is dropped
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      eopEnable_r <= ure_pkg::RST_EOP_EN; // [R1]
      burstSel_r <= ure_pkg::RST_BURST_SEL;
    end
    else if (wrTake)
    begin
      if (selLink && wb_sel_i[0])
        eopEnable_r <= wb_dat_i[ure_pkg::BIT_EOP_EN]; // [R1] [R13]
      else if (selMst && wb_sel_i[1])
        burstSel_r <= wb_dat_i[ure_pkg::BIT_BURST_SEL]; // [R8] [R13]
    end
  end

  // abort and path reset are single-cycle strobes
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      abort_r <= 1'b0;
      pathRst_r <= 1'b0;
    end
    else
    begin
      abort_r <= wrTake & selMst & wb_sel_i[0] &
                 wb_dat_i[ure_pkg::BIT_ABORT]; // [R11]
      pathRst_r <= wrTake & selMst & wb_sel_i[0] &
                   wb_dat_i[ure_pkg::BIT_PATH_RST]; // [R12]
    end
  end

  // run enable: software sets, finish/abort/reset clear it;
  // a stop request beats a simultaneous start
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      runEnable_r <= 1'b0;
    else if (abort_r | pathRst_r | readDone)
      runEnable_r <= 1'b0; // [R11] [R12]
    else if (wrTake & selMst & wb_sel_i[0] &
             wb_dat_i[ure_pkg::BIT_RUN_EN])
      runEnable_r <= 1'b1;
  end

  // ***********************************************
  // null packet sequencer
  // ***********************************************
  // a request while the endpoint holds data is ignored
  always_comb
  begin
    nullState_nxt = nullState_r;
    case (nullState_r)
      ure_pkg::NULL_IDLE:
        if (wrTake & selLink & wb_sel_i[0] & epEmpty &
            wb_dat_i[ure_pkg::BIT_NULL_REQ])
          nullState_nxt = ure_pkg::NULL_BUSY; // [R5] [R6]
      ure_pkg::NULL_BUSY:
        // a fresh accepted request in the done cycle keeps it busy
        if (nullDone && !(wrTake & selLink & wb_sel_i[0] & epEmpty &
            wb_dat_i[ure_pkg::BIT_NULL_REQ]))
          nullState_nxt = ure_pkg::NULL_IDLE; // [R6]
      default:
        nullState_nxt = ure_pkg::NULL_IDLE;
    endcase
  end

  // path reset also returns the sequencer to idle
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      nullState_r <= ure_pkg::NULL_IDLE;
    else if (pathRst_r)
      nullState_r <= ure_pkg::NULL_IDLE; // [R12]
    else
      nullState_r <= nullState_nxt;
  end

  // ***********************************************
  // burst code
  // ***********************************************
  // select picks INCR or INCR8 for burst beats; singles always get SINGLE
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      hburst_r <= ure_pkg::HBURST_SINGLE;
    else if (!beatIsBurst)
      hburst_r <= ure_pkg::HBURST_SINGLE; // [R9]
    else if (burstSel_r)
      hburst_r <= ure_pkg::HBURST_INCR; // [R8]
    else
      hburst_r <= ure_pkg::HBURST_INCR8; // [R8]
  end

  // ***********************************************
  // endpoint write decision
  // ***********************************************
  ure_eop_unit eopUnit (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .eopEnable(eopEnable_r),
    .runEnable(runEnable_r),
    .wordStrobe(wordStrobe),
    .wordIsLast(wordIsLast),
    .lastTwoBytes(lastTwoBytes),
    .epWrite_r(epWrite),
    .epWriteEop_r(epWriteEop)
  );

  assign wb_ack_o = ackR_r;
  assign wb_dat_o = rdData_r;
  assign endpointNullDataFlag = (nullState_r == ure_pkg::NULL_BUSY);
  assign readRunEnable = runEnable_r;
  assign readAbortPulse = abort_r;
  assign readPathResetPulse = pathRst_r;
  assign hburst = hburst_r;

  // ***********************************************
  // checks
  // ***********************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  chk_eop_reset_val: assert property ( // [R1]
    $rose(reset_n) |-> eopEnable_r)
    else $error("eop enable not set after reset");

  chk_one_byte_drop: assert property ( // [R2]
    (wordStrobe & wordIsLast & ~lastTwoBytes & ~eopEnable_r)
    |=> !epWrite)
    else $error("one-byte last word forwarded with eop off");

  chk_two_byte_noeop: assert property ( // [R3]
    (wordStrobe & wordIsLast & lastTwoBytes & ~eopEnable_r & runEnable_r)
    |=> epWrite && !epWriteEop)
    else $error("two-byte last word wrong with eop off");

  chk_eop_high: assert property ( // [R4]
    (wordStrobe & wordIsLast & eopEnable_r & runEnable_r)
    |=> epWrite && epWriteEop)
    else $error("last word lacks eop with eop on");

  chk_null_gate: assert property ( // [R5]
    (!endpointNullDataFlag && wrTake && selLink && !epEmpty)
    |=> !endpointNullDataFlag)
    else $error("null request taken while endpoint not empty");

  chk_null_hold: assert property ( // [R6]
    (endpointNullDataFlag && !nullDone && !pathRst_r)
    |=> endpointNullDataFlag)
    else $error("null flag dropped before packet sent");

  // the code is built from the select seen one edge earlier
  chk_burst_code: assert property ( // [R8]
    beatIsBurst |=> (hburst == ($past(burstSel_r) ? ure_pkg::HBURST_INCR
                                                  : ure_pkg::HBURST_INCR8)))
    else $error("burst code does not follow select");

  chk_single_code: assert property ( // [R9]
    !beatIsBurst |=> hburst == ure_pkg::HBURST_SINGLE)
    else $error("single access given a burst code");

  chk_abort_stop: assert property ( // [R11]
    (wrTake && selMst && wb_sel_i[0] && wb_dat_i[ure_pkg::BIT_ABORT])
    |=> readAbortPulse ##1 !readRunEnable)
    else $error("abort did not clear run enable");

  chk_reset_pulse: assert property ( // [R12]
    readPathResetPulse |=> !readPathResetPulse)
    else $error("path reset did not self-clear");

  cov_null_packet: cover property (
    $rose(endpointNullDataFlag) ##[1:20] $fell(endpointNullDataFlag));
  cov_eop_write: cover property (epWrite && epWriteEop);
  cov_abort_run: cover property (readRunEnable ##1 readAbortPulse);

endmodule // ure_read_ctrl

// *** core/ure_pkg.sv ***
// constants shared by the read-side bridge setting logic
package ure_pkg;

  // ***********************************************
  // register map (byte offsets on the bus)
  // ***********************************************
  localparam logic [3:0] ADDR_LINK_SET = 4'h0; // endpoint_link_setting
  localparam logic [3:0] ADDR_MST_SET = 4'h4;  // master_transfer_setting

  // ***********************************************
  // field positions
  // ***********************************************
  localparam int BIT_NULL_REQ = 0;    // null_packet_request
  localparam int BIT_EOP_EN = 4;      // read end-of-packet enable
  localparam int BIT_RUN_EN = 4;      // read_run_enable
  localparam int BIT_ABORT = 5;       // read_abort
  localparam int BIT_PATH_RST = 6;    // read_path_reset
  localparam int BIT_BURST_SEL = 8;   // burst type select

  // ***********************************************
  // reset values
  // ***********************************************
  localparam logic RST_EOP_EN = 1'h1;    // end-of-packet enabled
  localparam logic RST_BURST_SEL = 1'h0; // fixed eight-beat bursts

  // ***********************************************
  // system bus burst encodings
  // ***********************************************
  localparam logic [2:0] HBURST_SINGLE = 3'h0;
  localparam logic [2:0] HBURST_INCR = 3'h1;
  localparam logic [2:0] HBURST_INCR8 = 3'h5;

  // null packet sequencer, one-hot
  typedef enum logic [1:0] {
    NULL_IDLE = 2'h1,
    NULL_BUSY = 2'h2
  } ure_null_state_t;

endpackage

// *** core/ure_eop_unit.sv ***
// final-word forwarding decision toward the endpoint write port
`timescale 1ns/1ps
module ure_eop_unit (
  input wire logic ref_clk,      // bus clock
  input wire logic reset_n,      // async reset, active low
  input wire logic eopEnable,    // end-of-packet enable setting
  input wire logic runEnable,    // read transfer running
  input wire logic wordStrobe,   // one read word ready for endpoint
  input wire logic wordIsLast,   // this word ends the transfer
  input wire logic lastTwoBytes, // last word holds two bytes (else one)
  output logic epWrite_r,        // endpoint write pulse
  output logic epWriteEop_r      // end-of-packet flag with the write
);

  // forward while run is enabled, unless it is a one-byte last word with eop disabled
  logic forwardNxt;
  assign forwardNxt = wordStrobe & runEnable &
                      (~wordIsLast | eopEnable | lastTwoBytes); // [R2] [R11]

  // ***********************************************
  // registered endpoint write
  // ***********************************************
  // eop only rides the last word, and only when enabled
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      epWrite_r <= 1'b0;
      epWriteEop_r <= 1'b0;
    end
    else
    begin
      epWrite_r <= forwardNxt;
      epWriteEop_r <= forwardNxt & wordIsLast & eopEnable; // [R3] [R4]
    end
  end

endmodule // ure_eop_unit

// *** tb/ure_far_model.sv ***
// behavioural endpoint side of the usb core for the read bridge
`timescale 1ns/1ps
module ure_far_model (
  input wire logic ref_clk,              // bus clock
  input wire logic reset_n,              // async reset, active low
  input wire logic endpointNullDataFlag, // null packet request
  input wire logic slowAnswer,           // stretch the null packet time
  input wire logic holdData,             // endpoint still holds data
  output logic epEmpty,                  // endpoint empty status
  output logic nullDone                  // null packet sent, pulse
);
  logic [3:0] waitCnt_r; // cycles spent on the null packet

  // empty only while no read data is parked in the endpoint
  assign epEmpty = !holdData;

  // send the null packet, prompt or slow, and report it once
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      waitCnt_r <= 4'h0;
      nullDone <= 1'b0;
    end
    else if (nullDone)
    begin
      // flag drops after this edge, so no second report
      nullDone <= 1'b0;
      waitCnt_r <= 4'h0;
    end
    else if (endpointNullDataFlag)
    begin
      waitCnt_r <= waitCnt_r + 4'h1;
      nullDone <= (waitCnt_r == (slowAnswer ? 4'h8 : 4'h1));
    end
  end
endmodule // ure_far_model

// *** tb/usb_bridge_read_eop_ctrl_test.sv ***
// self-checking bench for the read-side bridge setting logic
`timescale 1ns/1ps
module usb_bridge_read_eop_ctrl_test;
  logic ref_clk = 1'b0;     // bus clock
  logic reset_n = 1'b0;     // reset, active low
  logic cyc = 1'b0;         // wishbone cycle
  logic stb = 1'b0;         // wishbone strobe
  logic we = 1'b0;          // wishbone write
  logic [3:0] adr = 4'h0;   // wishbone address
  logic [3:0] sel = 4'hF;   // wishbone byte lanes
  logic [31:0] wdat = '0;   // wishbone write data
  logic [31:0] rdat;        // wishbone read data
  logic ack;                // wishbone ack
  logic epEmpty, nullDone;  // from the far-side model
  logic readDone = 1'b0;    // read transfer finished
  logic wordStrobe = 1'b0;  // read word ready
  logic wordIsLast = 1'b0;  // word is the last
  logic lastTwoBytes = 1'b0; // last word width
  logic beatIsBurst = 1'b0; // next access is a burst
  logic slowAnswer = 1'b0;  // slow null packet
  logic holdData = 1'b0;    // endpoint not empty
  logic nullFlag, epWrite, epWriteEop, runEn, abortP, rstP;
  logic [2:0] hburst;       // burst code
  logic [31:0] q;           // last read value
  int n_fail = 0;           // mismatches
  int cmp_count = 0;        // comparisons
  int abortCnt = 0;         // cycles of abort pulse
  int rstCnt = 0;           // cycles of path reset pulse

  // ************************************************
  // clock, far side and design
  // ************************************************
  always #12.5 ref_clk = ~ref_clk;

  ure_far_model far (.ref_clk(ref_clk), .reset_n(reset_n),
    .endpointNullDataFlag(nullFlag), .slowAnswer(slowAnswer),
    .holdData(holdData), .epEmpty(epEmpty), .nullDone(nullDone));

  ure_read_ctrl dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .epEmpty(epEmpty), .nullDone(nullDone), .readDone(readDone),
    .wordStrobe(wordStrobe), .wordIsLast(wordIsLast),
    .lastTwoBytes(lastTwoBytes), .beatIsBurst(beatIsBurst),
    .endpointNullDataFlag(nullFlag), .epWrite(epWrite),
    .epWriteEop(epWriteEop), .readRunEnable(runEn),
    .readAbortPulse(abortP), .readPathResetPulse(rstP), .hburst(hburst));

  // pulse widths are counted so a stuck pulse shows up
  always @(posedge ref_clk)
  begin
    abortCnt += (abortP === 1'b1);
    rstCnt += (rstP === 1'b1);
  end

  // ************************************************
  // tasks
  // ************************************************
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one classic cycle; waits for ack as long as it takes,
  // only the watchdog ends a hung wait
  task automatic wbx(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    // the slave answers one cycle after it takes the request
    check("ack delay", n, 32'h2);
  endtask

  task automatic word(input logic last, input logic two,
                      input logic expW, input logic expE);
    @(posedge ref_clk);
    wordStrobe <= 1'b1;
    wordIsLast <= last;
    lastTwoBytes <= two;
    @(posedge ref_clk);
    wordStrobe <= 1'b0;
    #1;
    check("epWrite", {31'h0, epWrite}, {31'h0, expW});
    if (expW)
      check("epWriteEop", {31'h0, epWriteEop}, {31'h0, expE});
  endtask

  task automatic end_of_test;
    if (n_fail == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ************************************************
  // watchdog: the sequence needs well under 1000 cycles
  // ************************************************
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    end_of_test();
  end

  // ************************************************
  // main sequence
  // ************************************************
  initial
  begin
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    beatIsBurst <= 1'b1;
    wbx(0, 4'h0, '0);
    check("link reset", q, 32'h10);
    wbx(0, 4'h4, '0);
    check("mst reset", q, 32'h0);
    check("hburst incr8", hburst, ure_pkg::HBURST_INCR8);
    wbx(1, 4'h8, 32'hFFFFFFFF);
    wbx(0, 4'h8, '0);
    check("unmapped", q, 32'h0);
    wbx(1, 4'h0, 32'hFFFFFFEE);
    wbx(0, 4'h0, '0);
    check("unused bits", q, 32'h0);
    // with no byte lane enabled the write must not land
    sel <= 4'h0;
    wbx(1, 4'h0, 32'h10);
    sel <= 4'hF;
    wbx(0, 4'h0, '0);
    check("no lanes", q, 32'h0);
    // burst select is set once, before any transfer starts
    wbx(1, 4'h4, 32'h110);
    repeat (2) @(posedge ref_clk);
    #1;
    check("hburst incr", hburst, ure_pkg::HBURST_INCR);
    @(posedge ref_clk);
    beatIsBurst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    check("hburst single", hburst, ure_pkg::HBURST_SINGLE);
    @(posedge ref_clk);
    beatIsBurst <= 1'b1;
    word(1, 0, 0, 0);
    word(1, 1, 1, 0);
    word(0, 0, 1, 0);
    wbx(1, 4'h0, 32'h10);
    word(1, 0, 1, 1);
    word(1, 1, 1, 1);
    // null request refused while the endpoint holds data
    @(posedge ref_clk);
    holdData <= 1'b1;
    wbx(1, 4'h0, 32'h11);
    @(posedge ref_clk);
    #1;
    check("null refused", nullFlag, 1'b0);
    wbx(0, 4'h0, '0);
    check("null bit", q, 32'h10);
    holdData <= 1'b0;
    slowAnswer <= 1'b1;
    wbx(1, 4'h0, 32'h11);
    @(posedge ref_clk);
    #1;
    check("null flag", nullFlag, 1'b1);
    wbx(0, 4'h0, '0);
    check("null held", q, 32'h11);
    // software loads nothing new until the request bit clears
    for (int n = 0; n < 30 && nullFlag !== 1'b0; n++)
      @(posedge ref_clk);
    check("null clear", nullFlag, 1'b0);
    wbx(0, 4'h0, '0);
    check("null bit done", q, 32'h10);
    // prompt null packet: flag rises, then clears by itself
    slowAnswer <= 1'b0;
    wbx(1, 4'h0, 32'h11);
    @(posedge ref_clk);
    #1;
    check("null fast on", nullFlag, 1'b1);
    repeat (3) @(posedge ref_clk);
    #1;
    check("null fast off", nullFlag, 1'b0);
    // abort stops the run and blocks further words
    check("run on", runEn, 1'b1);
    wbx(1, 4'h4, 32'h120);
    repeat (3) @(posedge ref_clk);
    #1;
    check("abort run", runEn, 1'b0);
    check("abort pulse", abortCnt, 32'h1);
    word(1, 1, 0, 0);
    // a finished read transfer ends the run as well
    wbx(1, 4'h4, 32'h110);
    @(posedge ref_clk);
    #1;
    check("run again", runEn, 1'b1);
    @(posedge ref_clk);
    readDone <= 1'b1;
    @(posedge ref_clk);
    readDone <= 1'b0;
    @(posedge ref_clk);
    #1;
    check("done run", runEn, 1'b0);
    wbx(1, 4'h4, 32'h110);
    wbx(1, 4'h4, 32'h140);
    repeat (3) @(posedge ref_clk);
    #1;
    check("reset pulse", rstCnt, 32'h1);
    check("reset run", runEn, 1'b0);
    wbx(0, 4'h4, '0);
    check("reset bit", q, 32'h100);
    // a reset after the path reset stopped the run brings every setting back
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    wbx(0, 4'h0, '0);
    check("link again", q, 32'h10);
    wbx(0, 4'h4, '0);
    check("mst again", q, 32'h0);
    check("hburst again", hburst, ure_pkg::HBURST_INCR8);
    end_of_test();
  end
endmodule // usb_bridge_read_eop_ctrl_test
